// file: design/epts_pkg.sv
// Shared constants and types for the panel power sequencer pair
package epts_pkg;
	localparam int CLK_KHZ = 200000;
	localparam int MS_CYCLES_DEFAULT = CLK_KHZ;
	localparam int CYC_W = 18;
	localparam int MS_W = 10;
	// Panel side delays in ms, from supply on except valid detect, from video valid
	localparam int BLACK_DELAY_MS = 1;
	localparam int AUX_READY_MS = 1;
	localparam int HPD_DELAY_MS = 2;
	localparam int VALID_DETECT_MS = 1;
	// Source side delays, in ms; the sideband timeout in cycles
	localparam int HPD_MAX_MS = 200;
	localparam int HPD_TO_TRAIN_MS = 1;
	localparam int TRAIN_MS = 1;
	localparam int IDLE_MS = 1;
	localparam int BL_ON_MS = 100;
	localparam int LED_STEP_MS = 2;
	localparam int BL_OFF_TO_END_MS = 60;
	localparam int END_TO_OFF_MS = 10;
	localparam int POWER_OFF_MS = 500;
	localparam int AUX_TIMEOUT_CYC = 64;
	// Frame geometry
	localparam int H_ACTIVE = 1920;
	localparam int H_TOTAL = 2250;
	localparam int V_ACTIVE = 1080;
	localparam int V_TOTAL = 1132;
	// Pixel clock rates in kHz, made by a phase accumulator
	localparam int PIX_KHZ_60 = 152840;
	localparam int PIX_KHZ_50A = 127350;
	localparam int PIX_KHZ_50B = 122260;
	localparam int PH_W = 16;
	localparam logic [15:0] PIX_INC_60 =
		16'((64'(PIX_KHZ_60) << PH_W) / CLK_KHZ);
	localparam logic [15:0] PIX_INC_50A =
		16'((64'(PIX_KHZ_50A) << PH_W) / CLK_KHZ);
	localparam logic [15:0] PIX_INC_50B =
		16'((64'(PIX_KHZ_50B) << PH_W) / CLK_KHZ);
	// Sideband register address and capability byte
	localparam logic [19:0] SINK_STATUS_ADDR = 20'h00205;
	localparam logic [7:0] SINK_CAP_DEFAULT = 8'hA5;
	// Controller registers
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PATTERN = 8'h08;
	localparam int CTRL_POWER_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int STATUS_CLR_BIT = 8;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [31:0] PATTERN_RESET = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		S_OFF, S_SUPPLY, S_PRE_TRAIN, S_TRAIN, S_IDLE, S_VIDEO,
		S_BL_POWER, S_BL_DIM, S_ON, S_BL_UNEN, S_BL_UNDIM,
		S_VIDEO_END, S_POWER_END
	} epts_state_t;
endpackage

// file: design/epts_link_if.sv
// Link between the display source and the panel sink
`timescale 1ns/1ps
interface epts_link_if;
	logic panelSupply;
	logic hotPlug;
	logic auxReq;
	logic [19:0] auxAddr;
	logic auxAck;
	logic [7:0] auxData;
	logic trainActive;
	logic idlePattern;
	logic videoValid;
	logic noVideoFlag;
	logic pixelStrobe;
	logic activeVideoWindow;
	logic [23:0] pixelData;

	modport panel (
		input panelSupply, auxReq, auxAddr, trainActive, idlePattern,
		input videoValid, noVideoFlag, pixelStrobe, activeVideoWindow,
		input pixelData,
		output hotPlug, auxAck, auxData
	);
	modport source (
		output panelSupply, auxReq, auxAddr, trainActive, idlePattern,
		output videoValid, noVideoFlag, pixelStrobe, activeVideoWindow,
		output pixelData,
		input hotPlug, auxAck, auxData
	);
endinterface

// file: design/epts_panel_seq.sv
// Panel sink end: black video, hot plug, sideband answers, sink status
`timescale 1ns/1ps
module epts_panel_seq #(
	parameter int MS_CYCLES = epts_pkg::MS_CYCLES_DEFAULT,
	parameter logic [7:0] SINK_CAP = epts_pkg::SINK_CAP_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	epts_link_if.panel link,
	input wire logic blackDisable,
	output logic [7:0] displayRed,
	output logic [7:0] displayGreen,
	output logic [7:0] displayBlue,
	output logic displayStrobe,
	output logic displayWindow,
	output logic blackActive,
	output logic sinkStatus
);
	logic [epts_pkg::CYC_W-1:0] cycle, next_cycle;
	logic [epts_pkg::MS_W-1:0] onMs, next_onMs;
	logic [epts_pkg::MS_W-1:0] validMs, next_validMs;
	logic next_sinkStatus, next_blackActive;
	logic next_hotPlug, next_auxAck;
	logic [7:0] next_auxData;
	logic next_strobe, next_window;
	logic [23:0] pixel, next_pixel;
	logic msTick, auxReady;

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		msTick = cycle == epts_pkg::CYC_W'(MS_CYCLES - 1);
		next_cycle = msTick ? '0 : cycle + 1'b1;
		next_onMs = onMs;
		if (msTick && onMs != '1)
			next_onMs = onMs + 1'b1;
		auxReady = onMs >= epts_pkg::MS_W'(epts_pkg::AUX_READY_MS);
		next_validMs = validMs;
		if (msTick && link.videoValid && !sinkStatus)
			next_validMs = validMs + 1'b1;
		if (!link.videoValid)
			next_validMs = '0;
		next_sinkStatus = sinkStatus;
		if (validMs >= epts_pkg::MS_W'(epts_pkg::VALID_DETECT_MS))
			next_sinkStatus = 1'b1;
		if (link.noVideoFlag)
		begin
			next_sinkStatus = 1'b0;
			next_validMs = '0;
		end
		// Black video covers everything from BLACK_DELAY_MS after supply on until valid video is shown
		next_blackActive = !next_sinkStatus && !blackDisable
			&& onMs >= epts_pkg::MS_W'(epts_pkg::BLACK_DELAY_MS);
		// Sideband goes live before hot plug is raised
		next_hotPlug = auxReady
			&& onMs >= epts_pkg::MS_W'(epts_pkg::HPD_DELAY_MS);
		// Early requests get no answer; the source retries
		next_auxAck = link.auxReq && auxReady;
		next_auxData = link.auxData;
		if (link.auxReq && auxReady)
			next_auxData = link.auxAddr == epts_pkg::SINK_STATUS_ADDR
				? {7'h00, sinkStatus} : SINK_CAP;
		next_strobe = link.pixelStrobe;
		next_window = link.activeVideoWindow;
		// Codes pass straight through: 0 darkest, 255 brightest
		next_pixel = next_blackActive ? 24'h000000 : link.pixelData;
		if (!link.panelSupply)
		begin
			next_cycle = '0;
			next_onMs = '0;
			next_validMs = '0;
			next_sinkStatus = 1'b0;
			next_blackActive = 1'b0;
			next_hotPlug = 1'b0;
			next_auxAck = 1'b0;
			next_strobe = 1'b0;
			next_window = 1'b0;
			next_pixel = 24'h000000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cycle <= '0;
			onMs <= '0;
			validMs <= '0;
			sinkStatus <= 1'b0;
			blackActive <= 1'b0;
			link.hotPlug <= 1'b0;
			link.auxAck <= 1'b0;
			link.auxData <= 8'h00;
			displayStrobe <= 1'b0;
			displayWindow <= 1'b0;
			pixel <= 24'h000000;
		end
		else
		begin
			cycle <= next_cycle;
			onMs <= next_onMs;
			validMs <= next_validMs;
			sinkStatus <= next_sinkStatus;
			blackActive <= next_blackActive;
			link.hotPlug <= next_hotPlug;
			link.auxAck <= next_auxAck;
			link.auxData <= next_auxData;
			displayStrobe <= next_strobe;
			displayWindow <= next_window;
			pixel <= next_pixel;
		end
	end

	assign displayRed = pixel[23:16];
	assign displayGreen = pixel[15:8];
	assign displayBlue = pixel[7:0];
endmodule

// file: design/epts_source_seq.sv
// Source end: power sequence, link stages, pixel stream, AXI4-Lite regs
`timescale 1ns/1ps
module epts_source_seq #(
	parameter int MS_CYCLES = epts_pkg::MS_CYCLES_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	epts_link_if.source link,
	output logic backlightPower,
	output logic backlightDimming,
	output logic backlightEnable
);
	epts_pkg::epts_state_t state, next_state;
	logic [epts_pkg::CYC_W-1:0] cycle, next_cycle;
	logic [epts_pkg::MS_W-1:0] stateMs, next_stateMs;
	logic [31:0] ctrl, next_ctrl, pattern, next_pattern;
	logic awHeld, next_awHeld, wHeld, next_wHeld;
	logic [7:0] awAddrHeld, next_awAddrHeld;
	logic [31:0] wDataHeld, next_wDataHeld;
	logic [3:0] wStrbHeld, next_wStrbHeld;
	logic next_awready, next_wready, next_bvalid, next_arready;
	logic next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata, status;
	logic hpdPrev, hpdEvent, next_hpdEvent, errTimeout, next_errTimeout;
	logic auxPending, next_auxPending, auxBusy, next_auxBusy;
	logic [6:0] auxWait, next_auxWait;
	logic sinkSeen, next_sinkSeen;
	logic next_auxReq, next_supply, next_train, next_idle, next_valid;
	logic next_noVideo, next_blPower, next_blDim, next_blEnable;
	logic [epts_pkg::PH_W-1:0] phase, next_phase, inc;
	logic pixEn;
	logic [11:0] hCount, next_hCount;
	logic [10:0] vCount, next_vCount;
	logic next_strobe, next_window;
	logic [23:0] next_pixel;
	logic msTick, powerReq, clearReq, doWrite;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] result;
		result = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				result[8*i +: 8] = data[8*i +: 8];
		return result;
	endfunction

	function automatic logic elapsed(input logic [9:0] ms, input int lim);
		return ms >= 10'(lim);
	endfunction

	////////////////////////////////////////////////////////////////
	// Register slave
	always_comb
	begin
		next_awHeld = awHeld;
		next_awAddrHeld = awAddrHeld;
		next_wHeld = wHeld;
		next_wDataHeld = wDataHeld;
		next_wStrbHeld = wStrbHeld;
		if (awvalid && awready)
		begin
			next_awHeld = 1'b1;
			next_awAddrHeld = awaddr;
		end
		if (wvalid && wready)
		begin
			next_wHeld = 1'b1;
			next_wDataHeld = wdata;
			next_wStrbHeld = wstrb;
		end
		doWrite = awHeld && wHeld && !bvalid;
		next_ctrl = ctrl;
		next_pattern = pattern;
		clearReq = 1'b0;
		next_bvalid = bvalid && !bready;
		next_bresp = bresp;
		if (doWrite)
		begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = epts_pkg::RESP_OKAY;
			unique case (awAddrHeld)
				epts_pkg::ADDR_CTRL:
					next_ctrl = merge(ctrl, wDataHeld, wStrbHeld);
				epts_pkg::ADDR_PATTERN:
					next_pattern = merge(pattern, wDataHeld, wStrbHeld);
				epts_pkg::ADDR_STATUS:
					clearReq = wStrbHeld[1]
						&& wDataHeld[epts_pkg::STATUS_CLR_BIT];
				default:
					next_bresp = epts_pkg::RESP_SLVERR;
			endcase
		end
		next_awready = !next_awHeld && !next_bvalid;
		next_wready = !next_wHeld && !next_bvalid;
		status = {22'h000000, errTimeout, hpdEvent, sinkSeen,
			link.hotPlug, link.panelSupply, 1'b0, 4'(state)};
		next_rvalid = rvalid && !rready;
		next_rdata = rdata;
		next_rresp = rresp;
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = epts_pkg::RESP_OKAY;
			unique case (araddr)
				epts_pkg::ADDR_CTRL: next_rdata = ctrl;
				epts_pkg::ADDR_STATUS: next_rdata = status;
				epts_pkg::ADDR_PATTERN: next_rdata = pattern;
				default:
				begin
					next_rdata = 32'h00000000;
					next_rresp = epts_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrHeld <= 8'h00;
			wDataHeld <= 32'h00000000;
			wStrbHeld <= 4'h0;
			ctrl <= epts_pkg::CTRL_RESET;
			pattern <= epts_pkg::PATTERN_RESET;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'h0;
		end
		else
		begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddrHeld <= next_awAddrHeld;
			wDataHeld <= next_wDataHeld;
			wStrbHeld <= next_wStrbHeld;
			ctrl <= next_ctrl;
			pattern <= next_pattern;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////
	// Power sequence; every wait is counted in whole ms from entry
	always_comb
	begin
		powerReq = ctrl[epts_pkg::CTRL_POWER_BIT];
		msTick = cycle == epts_pkg::CYC_W'(MS_CYCLES - 1);
		next_state = state;
		next_errTimeout = errTimeout;
		unique case (state)
			epts_pkg::S_OFF:
				if (powerReq && elapsed(stateMs, epts_pkg::POWER_OFF_MS))
					next_state = epts_pkg::S_SUPPLY;
			epts_pkg::S_SUPPLY:
				if (link.hotPlug)
					next_state = epts_pkg::S_PRE_TRAIN;
				else if (elapsed(stateMs, epts_pkg::HPD_MAX_MS))
				begin
					next_errTimeout = 1'b1;
					next_state = epts_pkg::S_POWER_END;
				end
			epts_pkg::S_PRE_TRAIN:
				if (elapsed(stateMs, epts_pkg::HPD_TO_TRAIN_MS))
					next_state = epts_pkg::S_TRAIN;
			epts_pkg::S_TRAIN:
				if (elapsed(stateMs, epts_pkg::TRAIN_MS))
					next_state = epts_pkg::S_IDLE;
			epts_pkg::S_IDLE:
				if (elapsed(stateMs, epts_pkg::IDLE_MS))
					next_state = epts_pkg::S_VIDEO;
			epts_pkg::S_VIDEO:
				if (elapsed(stateMs, epts_pkg::BL_ON_MS))
					next_state = epts_pkg::S_BL_POWER;
			epts_pkg::S_BL_POWER:
				if (elapsed(stateMs, epts_pkg::LED_STEP_MS))
					next_state = epts_pkg::S_BL_DIM;
			epts_pkg::S_BL_DIM:
				if (elapsed(stateMs, epts_pkg::LED_STEP_MS))
					next_state = epts_pkg::S_ON;
			epts_pkg::S_ON:
				if (!powerReq)
					next_state = epts_pkg::S_BL_UNEN;
			epts_pkg::S_BL_UNEN:
				if (elapsed(stateMs, epts_pkg::LED_STEP_MS))
					next_state = epts_pkg::S_BL_UNDIM;
			epts_pkg::S_BL_UNDIM:
				if (elapsed(stateMs, epts_pkg::LED_STEP_MS))
					next_state = epts_pkg::S_VIDEO_END;
			epts_pkg::S_VIDEO_END:
				if (elapsed(stateMs, epts_pkg::BL_OFF_TO_END_MS))
					next_state = epts_pkg::S_POWER_END;
			epts_pkg::S_POWER_END:
				if (elapsed(stateMs, epts_pkg::END_TO_OFF_MS))
					next_state = epts_pkg::S_OFF;
		endcase
		// A drop before any video needs no backlight unwinding
		if (!powerReq && state inside {epts_pkg::S_SUPPLY,
			epts_pkg::S_PRE_TRAIN, epts_pkg::S_TRAIN, epts_pkg::S_IDLE})
			next_state = epts_pkg::S_POWER_END;
		if (powerReq && state == epts_pkg::S_OFF)
			next_errTimeout = 1'b0;
		next_cycle = msTick ? '0 : cycle + 1'b1;
		next_stateMs = stateMs;
		if (msTick && stateMs != '1)
			next_stateMs = stateMs + 1'b1;
		if (next_state != state)
		begin
			next_cycle = '0;
			next_stateMs = '0;
		end
		next_supply = next_state != epts_pkg::S_OFF;
		next_train = next_state == epts_pkg::S_TRAIN;
		next_idle = next_state inside {epts_pkg::S_IDLE,
			epts_pkg::S_POWER_END};
		next_valid = next_state inside {epts_pkg::S_VIDEO,
			epts_pkg::S_BL_POWER, epts_pkg::S_BL_DIM, epts_pkg::S_ON,
			epts_pkg::S_BL_UNEN, epts_pkg::S_BL_UNDIM,
			epts_pkg::S_VIDEO_END};
		next_noVideo = state == epts_pkg::S_VIDEO_END
			&& next_state == epts_pkg::S_POWER_END;
		next_blPower = next_state inside {epts_pkg::S_BL_POWER,
			epts_pkg::S_BL_DIM, epts_pkg::S_ON, epts_pkg::S_BL_UNEN,
			epts_pkg::S_BL_UNDIM};
		next_blDim = next_state inside {epts_pkg::S_BL_DIM,
			epts_pkg::S_ON, epts_pkg::S_BL_UNEN};
		next_blEnable = next_state == epts_pkg::S_ON;
		// Hot plug low pulse while video is valid: record it and reread sink status
		next_hpdEvent = (hpdEvent && !clearReq)
			|| (hpdPrev && !link.hotPlug && next_valid);
		next_auxPending = auxPending || (hpdPrev && !link.hotPlug
			&& next_valid);
		// Poll once power comes up; the panel may not answer yet
		if (state == epts_pkg::S_OFF && next_state == epts_pkg::S_SUPPLY)
			next_auxPending = 1'b1;
		next_auxReq = 1'b0;
		next_auxBusy = auxBusy;
		next_auxWait = auxWait;
		next_sinkSeen = sinkSeen;
		if (auxBusy)
		begin
			next_auxWait = auxWait + 1'b1;
			if (link.auxAck)
			begin
				next_auxBusy = 1'b0;
				next_sinkSeen = link.auxData[0];
			end
			else if (auxWait == 7'(epts_pkg::AUX_TIMEOUT_CYC - 1))
			begin
				next_auxBusy = 1'b0;
				next_auxPending = 1'b1;
			end
		end
		else if (auxPending)
		begin
			next_auxReq = 1'b1;
			next_auxBusy = 1'b1;
			next_auxWait = '0;
			next_auxPending = 1'b0;
		end
		if (!next_supply)
		begin
			next_auxPending = 1'b0;
			next_auxBusy = 1'b0;
			next_auxReq = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state <= epts_pkg::S_OFF;
			cycle <= '0;
			stateMs <= '0;
			errTimeout <= 1'b0;
			hpdPrev <= 1'b0;
			hpdEvent <= 1'b0;
			auxPending <= 1'b0;
			auxBusy <= 1'b0;
			auxWait <= '0;
			sinkSeen <= 1'b0;
			link.auxReq <= 1'b0;
			link.auxAddr <= 20'h00000;
			link.panelSupply <= 1'b0;
			link.trainActive <= 1'b0;
			link.idlePattern <= 1'b0;
			link.videoValid <= 1'b0;
			link.noVideoFlag <= 1'b0;
			backlightPower <= 1'b0;
			backlightDimming <= 1'b0;
			backlightEnable <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cycle <= next_cycle;
			stateMs <= next_stateMs;
			errTimeout <= next_errTimeout;
			hpdPrev <= link.hotPlug;
			hpdEvent <= next_hpdEvent;
			auxPending <= next_auxPending;
			auxBusy <= next_auxBusy;
			auxWait <= next_auxWait;
			sinkSeen <= next_sinkSeen;
			link.auxReq <= next_auxReq;
			link.auxAddr <= epts_pkg::SINK_STATUS_ADDR;
			link.panelSupply <= next_supply;
			link.trainActive <= next_train;
			link.idlePattern <= next_idle;
			link.videoValid <= next_valid;
			link.noVideoFlag <= next_noVideo;
			backlightPower <= next_blPower;
			backlightDimming <= next_blDim;
			backlightEnable <= next_blEnable;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pixel stream; the accumulator keeps the average rate in range
	always_comb
	begin
		unique case (ctrl[epts_pkg::CTRL_MODE_LSB +: 2])
			2'h1: inc = epts_pkg::PIX_INC_50A;
			2'h2: inc = epts_pkg::PIX_INC_50B;
			default: inc = epts_pkg::PIX_INC_60;
		endcase
		{pixEn, next_phase} = {1'b0, phase} + {1'b0, inc};
		next_hCount = hCount;
		next_vCount = vCount;
		if (pixEn)
		begin
			next_hCount = hCount + 1'b1;
			if (hCount == 12'(epts_pkg::H_TOTAL - 1))
			begin
				next_hCount = '0;
				next_vCount = vCount + 1'b1;
				if (vCount == 11'(epts_pkg::V_TOTAL - 1))
					next_vCount = '0;
			end
		end
		if (!link.videoValid)
		begin
			next_phase = '0;
			next_hCount = '0;
			next_vCount = '0;
		end
		next_strobe = pixEn && link.videoValid;
		next_window = hCount < 12'(epts_pkg::H_ACTIVE)
			&& vCount < 11'(epts_pkg::V_ACTIVE);
		next_pixel = next_window ? pattern[23:0] : 24'h000000;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			phase <= '0;
			hCount <= '0;
			vCount <= '0;
			link.pixelStrobe <= 1'b0;
			link.activeVideoWindow <= 1'b0;
			link.pixelData <= 24'h000000;
		end
		else
		begin
			phase <= next_phase;
			hCount <= next_hCount;
			vCount <= next_vCount;
			link.pixelStrobe <= next_strobe;
			link.activeVideoWindow <= next_window && next_strobe;
			link.pixelData <= next_pixel;
		end
	end
endmodule

// file: verif/epts_link_sva.sv
// Checker for the source to panel link and the backlight outputs
`timescale 1ns/1ps
module epts_link_sva #(
	parameter int MS_CYCLES = 20
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic panelSupply,
	input wire logic hotPlug,
	input wire logic auxReq,
	input wire logic auxAck,
	input wire logic trainActive,
	input wire logic idlePattern,
	input wire logic videoValid,
	input wire logic backlightPower,
	input wire logic backlightDimming,
	input wire logic backlightEnable
);
	logic [7:0] st;
	logic [7:0] stPrev;
	int stg;
	int off;
	assign st = {panelSupply, hotPlug, trainActive, idlePattern, videoValid,
		backlightPower, backlightDimming, backlightEnable};
	// One shared stage timer, restarted whenever any of the eight levels changes
	always_ff @(posedge clk)
	begin
		stPrev <= st;
		stg <= (reset || st != stPrev) ? 0 : stg + 1;
		off <= (reset || panelSupply) ? 0 : off + 1;
	end
	function automatic bit inr(int v, int lo, int hi);
		return v >= lo * MS_CYCLES && v <= hi * MS_CYCLES;
	endfunction
	////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_hpd; $rose(hotPlug) |-> panelSupply && inr(stg, 0, 200);
	endproperty
	a_hpd: assert property (p_hpd) else $error("hot plug late");
	property p_aux; auxReq && hotPlug |=> auxAck; endproperty
	a_aux: assert property (p_aux) else $error("aux unanswered");
	property p_tst; $rose(trainActive) |-> hotPlug && inr(stg, 0, 500);
	endproperty
	a_tst: assert property (p_tst) else $error("train start late");
	property p_tlen; $fell(trainActive) |-> idlePattern && inr(stg, 0, 500);
	endproperty
	a_tlen: assert property (p_tlen) else $error("train too long");
	property p_idle; $rose(videoValid) |-> inr(stg, 0, 500); endproperty
	a_idle: assert property (p_idle) else $error("idle too long");
	property p_blon; $rose(backlightPower) |-> videoValid && inr(stg, 80, 500);
	endproperty
	a_blon: assert property (p_blon) else $error("backlight on");
	property p_dimon;
		$rose(backlightDimming) |-> backlightPower && inr(stg, 1, 500);
	endproperty
	a_dimon: assert property (p_dimon) else $error("dimming on");
	property p_enon;
		$rose(backlightEnable) |-> backlightDimming && inr(stg, 1, 500);
	endproperty
	a_enon: assert property (p_enon) else $error("enable on");
	property p_dimoff;
		$fell(backlightDimming) |-> !backlightEnable && inr(stg, 1, 500);
	endproperty
	a_dimoff: assert property (p_dimoff) else $error("dimming off");
	property p_bloff;
		$fell(backlightPower) |-> !backlightDimming && inr(stg, 1, 500);
	endproperty
	a_bloff: assert property (p_bloff) else $error("backlight off");
	property p_vend; $fell(videoValid) |-> !backlightPower && inr(stg, 50, 500);
	endproperty
	a_vend: assert property (p_vend) else $error("video end");
	property p_sup; $fell(panelSupply) |-> !videoValid && inr(stg, 0, 500);
	endproperty
	a_sup: assert property (p_sup) else $error("supply off late");
	// Two cycles of slack for the counter's own registering
	property p_offt; $rose(panelSupply) |-> off >= 500 * MS_CYCLES - 2;
	endproperty
	a_offt: assert property (p_offt) else $error("off time short");
	c_on: cover property ($rose(backlightEnable));
	c_down: cover property ($fell(panelSupply));
	c_poll: cover property (auxReq && !hotPlug);
endmodule

// file: verif/tb_edp_panel_timing_power_seq.sv
// Bench joining the source and panel sequencers across their link
`timescale 1ns/1ps
`define CHK(n, e, a) begin testsRun++; if ((e) !== (a)) begin fails++; \
$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_edp_panel_timing_power_seq;
	localparam int MS = 20;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, blackDisable = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, displayStrobe;
	logic displayWindow, blackActive, sinkStatus;
	logic backlightPower, backlightDimming, backlightEnable;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] displayRed, displayGreen, displayBlue;
	logic [65:0] e;
	logic [1:0] wrQ[$];
	logic [65:0] rdQ[$];
	logic [23:0] pat;
	int fails = 0, testsRun = 0, c;
	int lo[4] = '{1516, 1263, 1213, 1516};
	int hi[4] = '{1540, 1283, 1232, 1540};
	epts_link_if link();
	epts_source_seq #(.MS_CYCLES(MS)) i_epts_source_seq (.clk(clk),
		.reset(reset), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .link(link),
		.backlightPower(backlightPower), .backlightDimming(backlightDimming),
		.backlightEnable(backlightEnable));
	epts_panel_seq #(.MS_CYCLES(MS)) i_epts_panel_seq (.clk(clk),
		.reset(reset), .link(link), .blackDisable(blackDisable),
		.displayRed(displayRed), .displayGreen(displayGreen),
		.displayBlue(displayBlue), .displayStrobe(displayStrobe),
		.displayWindow(displayWindow), .blackActive(blackActive),
		.sinkStatus(sinkStatus));
	epts_link_sva #(.MS_CYCLES(MS)) i_epts_link_sva (.clk(clk), .reset(reset),
		.panelSupply(link.panelSupply), .hotPlug(link.hotPlug),
		.auxReq(link.auxReq), .auxAck(link.auxAck),
		.trainActive(link.trainActive), .idlePattern(link.idlePattern),
		.videoValid(link.videoValid), .backlightPower(backlightPower),
		.backlightDimming(backlightDimming), .backlightEnable(backlightEnable));
	initial forever #2.5 clk = ~clk;
	////////////////////////////////////////
	task automatic finalReport();
		$display("COUNTS run %0d fails %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chkto(logic bad);
		if (bad)
		begin
			fails++;
			finalReport();
		end
	endtask
	function automatic logic [1:0] rsp(logic [7:0] a);
		return a inside {epts_pkg::ADDR_CTRL, epts_pkg::ADDR_STATUS,
			epts_pkg::ADDR_PATTERN} ? epts_pkg::RESP_OKAY
			: epts_pkg::RESP_SLVERR;
	endfunction
	task automatic wr(logic [7:0] a, logic [31:0] d);
		int n;
		wrQ.push_back(rsp(a));
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && !(bvalid && bready); n++)
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chkto(n == 50);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] d);
		int n;
		rdQ.push_back({m, rsp(a), d & m});
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && !(rvalid && rready); n++)
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chkto(n == 50);
	endtask
	always @(posedge clk)
	begin
		if (bvalid && bready)
		begin
			e[1:0] = wrQ.pop_front();
			`CHK("bresp", e[1:0], bresp)
		end
		if (rvalid && rready)
		begin
			e = rdQ.pop_front();
			`CHK("rresp", e[33:32], rresp)
			`CHK("rdata", e[31:0], rdata & e[65:34])
		end
	end
	function automatic logic sel(int i);
		case (i)
			0: return link.panelSupply;
			1: return link.hotPlug;
			2: return link.videoValid;
			3: return sinkStatus;
			4: return blackActive;
			default: return backlightEnable;
		endcase
	endfunction
	task automatic waitv(int i, logic v, int lim);
		int n;
		for (n = 0; n < lim && sel(i) !== v; n++)
		begin
			@(posedge clk);
			#1;
		end
		chkto(sel(i) !== v);
	endtask
	// Counts one whole line from the first active pixel after a blank one
	task automatic line_chk(logic [23:0] p);
		int n, ph, act, tot;
		logic w;
		logic [23:0] col, wp;
		ph = 0;
		act = 0;
		tot = 0;
		w = 1'b1;
		for (n = 0; n < 12000 && ph < 2; n++)
		begin
			@(posedge clk);
			#1;
			if (displayStrobe && displayWindow)
				col = {displayRed, displayGreen, displayBlue};
			if (link.pixelStrobe)
			begin
				if (link.activeVideoWindow && !w) ph++;
				if (link.activeVideoWindow) wp = link.pixelData;
				if (ph == 1) tot++;
				if (ph == 1) act += int'(link.activeVideoWindow);
				w = link.activeVideoWindow;
			end
		end
		chkto(ph < 2);
		`CHK("active", 1920, act)
		`CHK("total", 1'b1, tot >= 2240 && tot <= 2260)
		`CHK("wire", p, wp)
		`CHK("colour", p, col)
	endtask
	////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h809287E0));
		pat = 24'($urandom);
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd(epts_pkg::ADDR_CTRL, 32'hFFFFFFFF, epts_pkg::CTRL_RESET);
		rd(epts_pkg::ADDR_PATTERN, 32'hFFFFFFFF, epts_pkg::PATTERN_RESET);
		rd(epts_pkg::ADDR_STATUS, 32'h000003FF, 32'h00000000);
		wr(8'h0C, 32'hFFFFFFFF);
		rd(8'h0C, 32'hFFFFFFFF, 32'h00000000);
		rd(epts_pkg::ADDR_CTRL, 32'hFFFFFFFF, epts_pkg::CTRL_RESET);
		$display("TEST regs done");
		wr(epts_pkg::ADDR_PATTERN, 32'(pat));
		wr(epts_pkg::ADDR_CTRL, 32'h00000001);
		waitv(0, 1'b1, 12000);
		waitv(4, 1'b1, 200 * MS);
		waitv(1, 1'b1, 200 * MS);
		waitv(2, 1'b1, 20 * MS);
		waitv(3, 1'b1, 50 * MS);
		`CHK("black", 1'b0, blackActive)
		line_chk(pat);
		for (int m = 0; m < 4; m++)
		begin
			wr(epts_pkg::ADDR_CTRL, 32'(m << epts_pkg::CTRL_MODE_LSB) | 32'h1);
			repeat (20) @(posedge clk);
			c = 0;
			repeat (2000) @(posedge clk) c += int'(link.pixelStrobe);
			`CHK("rate", 1'b1, c >= lo[m] && c <= hi[m])
		end
		waitv(5, 1'b1, 600 * MS);
		`CHK("bl", 2'b11, {backlightPower, backlightDimming})
		rd(epts_pkg::ADDR_STATUS, 32'h0000006F, 32'h00000068);
		$display("TEST power up done");
		wr(epts_pkg::ADDR_CTRL, 32'h00000000);
		waitv(2, 1'b0, 200 * MS);
		waitv(3, 1'b0, 3);
		waitv(4, 1'b1, 3);
		waitv(0, 1'b0, 600 * MS);
		@(posedge clk);
		blackDisable <= 1'b1;
		wr(epts_pkg::ADDR_CTRL, 32'h00000001);
		waitv(1, 1'b1, 800 * MS);
		`CHK("nobl", 1'b0, blackActive)
		$display("TEST power down done");
		finalReport();
	end
endmodule
